//--- acs_regs.vh
/*
 * register offsets, field positions, reset values and codes of the
 * conversion sequencer. assumes a 32-bit ahb-lite slave, word aligned.
 */
//----------------------------------------------------------------
// Contract
// - trigger accepted only with code 1011 and enabled
// - accepted trigger sets go, clears capture timer
// - disabled converter ignores trigger, timer still cleared
// - reset restores registers, disables, aborts conversion
// - reset leaves result registers unchanged
// - result registers undefined after power-on
// - clearing go halts, unconverted bits read zero
// - acquisition period fixed regardless of resolution
// - n bits take n plus one bit periods
// - full conversion gives twelve-bit split result
//----------------------------------------------------------------
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

//----------------------------------------------------------------
// offsets
//----------------------------------------------------------------
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_MODE 8'h04
`define ACS_OFF_RESH 8'h08
`define ACS_OFF_RESL 8'h0C
`define ACS_OFF_STAT 8'h10
`define ACS_OFF_MASK 8'h14
`define ACS_OFF_TAD 8'h18

//----------------------------------------------------------------
// fields
//----------------------------------------------------------------
`define ACS_CTRL_EN 0
`define ACS_CTRL_GO 1
`define ACS_CTRL_CH_LO 4
`define ACS_CTRL_CH_HI 7
`define ACS_STAT_DONE 0
`define ACS_TRIG_CODE 4'hB

//----------------------------------------------------------------
// reset values and timing
//----------------------------------------------------------------
`define ACS_RST_CTRL 8'h00
`define ACS_RST_MODE 4'h0
`define ACS_RST_MASK 1'b0
`define ACS_RST_TAD 8'h1F
`define ACS_ACQ_TADS 8
`define ACS_RES_BITS 12

`endif

//--- acs_sequencer.v
/*
 * successive-approximation conversion sequencer with ahb-lite register
 * access, special event trigger from the capture/compare unit and early
 * termination. assumes the analog core presents one decided result bit
 * on conv_bit_pin near the end of each bit period, and the trigger and
 * mode field come from logic on ref_clk.
 */
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_sequencer #(
	parameter RES_BITS = `ACS_RES_BITS,
	parameter ACQ_TADS = `ACS_ACQ_TADS
) (
	// clock, reset, enable
	input wire ref_clk,
	input wire srst,
	input wire ce,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// capture/compare unit
	input wire special_trigger,
	output reg capture_timer_clear,
	output reg [3:0] capture_compare_mode_field,
	// analog core
	input wire conv_bit_pin,
	output reg sample_en,
	output reg convert_en,
	output reg [3:0] bit_sel,
	output reg [3:0] channel_sel,
	// interrupt
	output reg irq
);

	//----------------------------------------------------------------
	// states
	//----------------------------------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_ACQ = 2'd1;
	localparam ST_SETTLE = 2'd2;
	localparam ST_CONV = 2'd3;

	//----------------------------------------------------------------
	// derived constants and shared decode
	//----------------------------------------------------------------
	localparam integer TOP_BIT_I = RES_BITS - 1;
	localparam integer ACQ_LAST_I = ACQ_TADS - 1;
	localparam [3:0] TOP_BIT = TOP_BIT_I[3:0];
	localparam [7:0] ACQ_LAST = ACQ_LAST_I[7:0];
	localparam [7:0] RST_CTRL = `ACS_RST_CTRL;

	// the trigger code is decoded for both the start and the timer clear
	function is_trig_code;
		input [3:0] m;
		begin
			is_trig_code = (m == `ACS_TRIG_CODE);
		end
	endfunction

	//----------------------------------------------------------------
	// storage
	//----------------------------------------------------------------
	reg converter_enable_bit;
	reg go;
	reg [7:0] tad_div;
	reg done_flag;
	reg done_mask;
	reg [11:0] result_reg;
	reg [1:0] state;
	reg [7:0] tad_cnt;
	reg [7:0] acq_cnt;
	reg [3:0] bit_idx;
	reg [11:0] acc;
	reg bit_meta;
	reg bit_sync;
	reg wr_pend;
	reg [7:0] wr_addr;

	wire addr_phase = hsel & htrans[1] & hready;
	// writes outside the low 256 bytes are dropped, like reads there
	wire wr_hit = addr_phase & hwrite & (haddr[31:8] == 24'h0000_00);
	wire tad_tick = (tad_cnt == tad_div);
	wire [7:0] hi_bits = {4'h0, result_reg[11:8]};
	wire [7:0] lo_bits = result_reg[7:0];
	wire wr_ctrl = wr_pend & (wr_addr == `ACS_OFF_CTRL);
	wire wr_go_val = hwdata[`ACS_CTRL_GO];
	wire wr_en_val = hwdata[`ACS_CTRL_EN];
	wire trig_ok = special_trigger & converter_enable_bit & is_trig_code(capture_compare_mode_field);
	wire sw_start = wr_ctrl & wr_go_val & wr_en_val & (state == ST_IDLE);
	wire sw_halt = wr_ctrl & ~wr_go_val & (state != ST_IDLE);
	wire sw_abort = wr_ctrl & ~wr_en_val;
	wire wr_done_clr = wr_pend & (wr_addr == `ACS_OFF_STAT) & hwdata[`ACS_STAT_DONE];
	wire last_bit = (state == ST_CONV) & tad_tick & (bit_idx == 4'd0);
	wire [11:0] acc_now = acc | ({11'h000, bit_sync} << bit_idx);

	//----------------------------------------------------------------
	// read mux
	//----------------------------------------------------------------
	function [31:0] rd_mux;
		input [7:0] a;
		begin
			case (a)
				`ACS_OFF_CTRL: rd_mux = {24'h0000_00, channel_sel, 2'b00, go, converter_enable_bit};
				`ACS_OFF_MODE: rd_mux = {28'h000_0000, capture_compare_mode_field};
				`ACS_OFF_RESH: rd_mux = {24'h0000_00, hi_bits};
				`ACS_OFF_RESL: rd_mux = {24'h0000_00, lo_bits};
				`ACS_OFF_STAT: rd_mux = {31'h0000_0000, done_flag};
				`ACS_OFF_MASK: rd_mux = {31'h0000_0000, done_mask};
				`ACS_OFF_TAD: rd_mux = {24'h0000_00, tad_div};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	endfunction

	//----------------------------------------------------------------
	// pin synchroniser
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (ce) begin
			bit_meta <= conv_bit_pin;
			bit_sync <= bit_meta;
		end
	end

	//----------------------------------------------------------------
	// bus slave
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= wr_hit;
			wr_addr <= haddr[7:0];
			if (addr_phase & ~hwrite)
				hrdata <= (haddr[31:8] == 24'h0000_00) ? rd_mux(haddr[7:0]) : 32'h0000_0000;
		end
	end

	//----------------------------------------------------------------
	// configuration registers
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			converter_enable_bit <= RST_CTRL[`ACS_CTRL_EN];
			channel_sel <= RST_CTRL[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO];
			capture_compare_mode_field <= `ACS_RST_MODE;
			done_mask <= `ACS_RST_MASK;
			tad_div <= `ACS_RST_TAD;
		end else if (ce && wr_pend) begin
			case (wr_addr)
				`ACS_OFF_CTRL: begin
					converter_enable_bit <= wr_en_val;
					channel_sel <= hwdata[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO];
				end
				`ACS_OFF_MODE: capture_compare_mode_field <= hwdata[3:0];
				`ACS_OFF_MASK: done_mask <= hwdata[`ACS_STAT_DONE];
				`ACS_OFF_TAD: tad_div <= hwdata[7:0];
				default: tad_div <= tad_div;
			endcase
		end
	end

	//----------------------------------------------------------------
	// status flag and interrupt
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			done_flag <= 1'b0;
			irq <= 1'b0;
		end else if (ce) begin
			if (last_bit)
				done_flag <= 1'b1;
			else if (wr_done_clr)
				done_flag <= 1'b0;
			irq <= (done_flag | last_bit) & done_mask;
		end
	end

	//----------------------------------------------------------------
	// capture timer clear
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst)
			capture_timer_clear <= 1'b0;
		else if (ce)
			capture_timer_clear <= special_trigger & is_trig_code(capture_compare_mode_field);
	end

	//----------------------------------------------------------------
	// result registers, kept across reset
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (ce) begin
			if (last_bit)
				result_reg <= acc_now;
			else if (sw_halt)
				result_reg <= acc;
		end
	end

	//----------------------------------------------------------------
	// conversion sequencer
	//----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_IDLE;
			go <= 1'b0;
			tad_cnt <= 8'h00;
			acq_cnt <= 8'h00;
			bit_idx <= 4'h0;
			acc <= 12'h000;
			sample_en <= 1'b0;
			convert_en <= 1'b0;
			bit_sel <= 4'h0;
		end else if (ce) begin
			tad_cnt <= (tad_tick || state == ST_IDLE) ? 8'h00 : tad_cnt + 8'h01;
			case (state)
				ST_IDLE: begin
					if (trig_ok || sw_start) begin
						go <= 1'b1;
						state <= ST_ACQ;
						acq_cnt <= 8'h00;
						acc <= 12'h000;
						sample_en <= 1'b1;
					end
				end
				ST_ACQ: begin
					if (tad_tick) begin
						acq_cnt <= acq_cnt + 8'h01;
						if (acq_cnt == ACQ_LAST) begin
							state <= ST_SETTLE;
							sample_en <= 1'b0;
							convert_en <= 1'b1;
							// top index shown from the settling period on, never a stale one
							bit_idx <= TOP_BIT;
							bit_sel <= TOP_BIT;
						end
					end
				end
				ST_SETTLE: begin
					if (tad_tick) begin
						state <= ST_CONV;
						bit_idx <= TOP_BIT;
						bit_sel <= TOP_BIT;
					end
				end
				ST_CONV: begin
					if (tad_tick) begin
						acc <= acc_now;
						bit_idx <= bit_idx - 4'h1;
						bit_sel <= bit_idx - 4'h1;
						if (bit_idx == 4'h0) begin
							state <= ST_IDLE;
							go <= 1'b0;
							convert_en <= 1'b0;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
			// a halt keeps the decided bits; an abort by disabling keeps them only when go is also written 0
			if (sw_halt || sw_abort) begin
				state <= ST_IDLE;
				go <= 1'b0;
				sample_en <= 1'b0;
				convert_en <= 1'b0;
			end
		end
	end

endmodule // acs_sequencer

//--- acs_properties.sv
/* port checker of the conversion sequencer.
 assumes it is bound to acs_sequencer, one clock. */
`timescale 1ns/1ps
module acs_properties #(
	parameter RES_BITS = 12,
	parameter ACQ_TADS = 8
) (
	// clock, reset
	input wire ref_clk,
	input wire srst,
	// watched
	input wire special_trigger,
	input wire capture_timer_clear,
	input wire [3:0] capture_compare_mode_field,
	input wire sample_en,
	input wire convert_en,
	input wire [3:0] bit_sel,
	input wire irq
);
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (srst);
wire trig_b = special_trigger && capture_compare_mode_field == 4'hB;
clr_due_a: assert property (trig_b |=> capture_timer_clear)
	else $error("clear missing");
clr_cause_a: assert property (capture_timer_clear |-> $past(trig_b))
	else $error("stray clear");
clr_pulse_a: assert property (capture_timer_clear |=> !capture_timer_clear)
	else $error("clear too long");
phase_excl_a: assert property (!(sample_en && convert_en))
	else $error("phases overlap");
acq_conv_a: assert property ($fell(sample_en) |-> convert_en)
	else $error("no settle");
bit_down_a: assert property (convert_en && $past(convert_en) && bit_sel != $past(bit_sel) |->
	bit_sel == $past(bit_sel) - 4'h1 || (bit_sel == 4'hB && $past(bit_sel) == 4'h0))
	else $error("bit order");
irq_idle_a: assert property ($rose(irq) |-> !convert_en && !sample_en)
	else $error("irq early");
rst_off_a: assert property (disable iff (1'b0) srst |=> !sample_en && !convert_en && !irq)
	else $error("reset left on");
cover property (trig_b);
cover property ($rose(irq));
cover property ($fell(convert_en) && bit_sel != 4'hF);
endmodule // acs_properties
bind acs_sequencer acs_properties #(.RES_BITS(RES_BITS), .ACQ_TADS(ACQ_TADS)) acs_properties_inst (
	.ref_clk(ref_clk), .srst(srst), .special_trigger(special_trigger),
	.capture_timer_clear(capture_timer_clear), .capture_compare_mode_field(capture_compare_mode_field),
	.sample_en(sample_en), .convert_en(convert_en), .bit_sel(bit_sel), .irq(irq));

//--- acs_partner.sv
/* trigger source and analog core model.
 assumes the bench requests triggers on fire. */
`timescale 1ns/1ps
module acs_partner #(
	parameter [11:0] PAT = 12'hA5C
) (
	// bench side
	input wire ref_clk,
	input wire fire,
	// sequencer side
	input wire convert_en,
	input wire [3:0] bit_sel,
	output logic special_trigger = 1'b0,
	output logic conv_bit_pin = 1'b0
);
always @(posedge ref_clk) begin
	special_trigger <= fire;
	// outside the settle and bit periods the line toggles so a stray sample shows
	if (convert_en && bit_sel < 4'hC)
		conv_bit_pin <= PAT[bit_sel];
	else
		conv_bit_pin <= ~conv_bit_pin;
end
endmodule // acs_partner

//--- acs_sequencer_test.sv
/* self-checking bench of the conversion sequencer.
 assumes the partner model and a zero-wait slave. */
`timescale 1ns/1ps
module acs_sequencer_test;
logic ref_clk = 1'b0, srst = 1'b1, hwrite = 1'b0, fire = 1'b0;
logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
logic [1:0] htrans = 2'h0;
wire [31:0] hrdata;
wire hreadyout, hresp, special_trigger, capture_timer_clear, conv_bit_pin, sample_en, convert_en, irq;
wire [3:0] capture_compare_mode_field, bit_sel, channel_sel;
int mismatches = 0, check_count = 0;
always #5 ref_clk = ~ref_clk;
acs_sequencer #(.ACQ_TADS(2)) acs_sequencer_inst (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
	.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
	.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.special_trigger(special_trigger), .capture_timer_clear(capture_timer_clear),
	.capture_compare_mode_field(capture_compare_mode_field), .conv_bit_pin(conv_bit_pin),
	.sample_en(sample_en), .convert_en(convert_en), .bit_sel(bit_sel), .channel_sel(channel_sel), .irq(irq));
acs_partner acs_partner_inst (.ref_clk(ref_clk), .fire(fire), .convert_en(convert_en), .bit_sel(bit_sel),
	.special_trigger(special_trigger), .conv_bit_pin(conv_bit_pin));
task give_verdict;
	if (mismatches == 0 && check_count > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
	check_count++;
	if (got !== exp) begin
		mismatches++;
		$display("[FAIL] %s expected %h seen %h", nm, exp, got);
	end
endtask
task hang;
	mismatches++;
	give_verdict;
endtask
task rdy;
	int n;
	n = 0;
	do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 20);
	if (n >= 20) hang;
endtask
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
	htrans <= 2'h2;
	haddr <= {24'h0, a};
	hwrite <= w;
	rdy;
	htrans <= 2'h0;
	hwdata <= d;
	rdy;
	rd = hrdata;
endtask
task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
	xfer(1'b0, a, 32'h0);
	chk(nm, rd, e);
endtask
task pulse(input logic c, input logic e);
	fire <= 1'b1;
	@(posedge ref_clk);
	fire <= 1'b0;
	@(posedge ref_clk);
	@(negedge ref_clk);
	chk("clear", 32'(capture_timer_clear), 32'(c));
	repeat (2) @(posedge ref_clk);
	chk("start", 32'(sample_en), 32'(e));
endtask
task sc_trigger;
	int k;
	xfer(1'b1, 8'h18, 32'h7);
	xfer(1'b1, 8'h14, 32'h1);
	xfer(1'b1, 8'h04, 32'hB);
	// channel chosen before the trigger
	xfer(1'b1, 8'h00, 32'h31);
	pulse(1'b1, 1'b1);
	chk("channel", 32'(channel_sel), 32'h3);
	rdc("busy", 8'h00, 32'h33);
	k = 0;
	do xfer(1'b0, 8'h10, 32'h0); while (rd[0] !== 1'b1 && ++k < 200);
	if (k >= 200) hang;
	chk("irq", 32'(irq), 32'h1);
	rdc("ctrl", 8'h00, 32'h31);
	rdc("high", 8'h08, 32'hA);
	rdc("low", 8'h0C, 32'h5C);
	xfer(1'b1, 8'h14, 32'h0);
	rdc("stat", 8'h10, 32'h1);
	chk("masked", 32'(irq), 32'h0);
	xfer(1'b1, 8'h10, 32'h1);
	rdc("w1c", 8'h10, 32'h0);
endtask
task sc_ignored;
	xfer(1'b1, 8'h00, 32'h30);
	pulse(1'b1, 1'b0);
	xfer(1'b1, 8'h04, 32'hA);
	xfer(1'b1, 8'h00, 32'h31);
	pulse(1'b0, 1'b0);
endtask
task sc_halt;
	int n;
	xfer(1'b1, 8'h00, 32'h33);
	n = 0;
	do @(posedge ref_clk); while (!(convert_en === 1'b1 && bit_sel === 4'h7) && ++n < 300);
	if (n >= 300) hang;
	// four bits decided, halt timed by software
	xfer(1'b1, 8'h00, 32'h31);
	repeat (4) @(posedge ref_clk);
	chk("halted", 32'(convert_en), 32'h0);
	rdc("high", 8'h08, 32'hA);
	rdc("low", 8'h0C, 32'h0);
	rdc("done", 8'h10, 32'h0);
endtask
task sc_reset;
	xfer(1'b1, 8'h00, 32'h33);
	repeat (5) @(posedge ref_clk);
	srst <= 1'b1;
	repeat (2) @(posedge ref_clk);
	srst <= 1'b0;
	@(posedge ref_clk);
	chk("mode", 32'(capture_compare_mode_field), 32'h0);
	chk("resp", 32'(hresp), 32'h0);
	rdc("ctrl", 8'h00, 32'h0);
	rdc("tad", 8'h18, 32'h1F);
	rdc("high", 8'h08, 32'hA);
	rdc("low", 8'h0C, 32'h0);
	rdc("hole", 8'h40, 32'h0);
endtask
initial begin
	repeat (2) @(posedge ref_clk);
	srst <= 1'b0;
	sc_trigger;
	sc_ignored;
	sc_halt;
	sc_reset;
	give_verdict;
end
endmodule // acs_sequencer_test
